// >>> rtl/dmd_params.svh
// constants for the dual modulus divider control block
`ifndef DMD_PARAMS_SVH
`define DMD_PARAMS_SVH
`define DMD_CNT_W 16
`define DMD_DIG_W 5
`define DMD_MODE_W 2
`define DMD_REG_MAIN 12'h000
`define DMD_REG_SWAL 12'h004
`define DMD_REG_MODE 12'h008
`define DMD_REG_STAT 12'h00C
`define DMD_MAIN_RST 16'h000A
`define DMD_SWAL_RST 16'h0000
`define DMD_UNITS_SHIFT 0
`define DMD_TENS_SHIFT 8
`define DMD_UNITS_MAX_PAR 5'h09
`define DMD_UNITS_MIN_SER 5'h0A
`define DMD_UNITS_MAX_SER 5'h13
`define DMD_TENS_MAX 5'h09
`define DMD_SWAL_SPAN 16'h000A
`define DMD_MAIN_MIN_PAR 16'h000A
`define DMD_MAIN_MIN_SER 16'h0014
`define DMD_RESP_OKAY 2'h0
`define DMD_RESP_SLVERR 2'h2
`endif

// >>> rtl/dmd_pkg.sv
// types for the dual modulus divider control block
package dmd_pkg;
  typedef enum logic [1:0]
  {
    DMD_TWO = 2'b00,
    DMD_FOUR = 2'b01,
    DMD_THREE = 2'b10
  } dmd_mode_t;
endpackage

// >>> rtl/dmd_cfg_if.sv
// configuration carried from the register slave to the counters
`timescale 1ns/10ps
interface dmd_cfg_if;
  logic [15:0] main_val;
  logic [15:0] swal_val;
  logic [1:0] mode;
  logic [15:0] main_cnt;
  logic [15:0] swal_cnt;
  logic mod_sel;
  logic cfg_err;
  modport slave (output main_val, output swal_val, output mode,
                 input main_cnt, input swal_cnt, input mod_sel, input cfg_err);
  modport core (input main_val, input swal_val, input mode,
                output main_cnt, output swal_cnt, output mod_sel, output cfg_err);
endinterface

// >>> rtl/dmd_counters.sv
// main and swallow counters driving the prescaler modulus select
`timescale 1ns/10ps
`include "dmd_params.svh"
module dmd_counters
(
  input wire logic aclk, // prescaler output clock
  input wire logic aresetn, // synchronous reset, active low
  dmd_cfg_if.core cfg, // programmed values and live state
  output logic [1:0] modulus_sel, // bit0 adds unit step, bit1 adds tens step
  output logic cycle_end // one-cycle end of division pulse
);
  import dmd_pkg::*;
  logic [15:0] main_cnt;
  logic [4:0] units_swallow_counter;
  logic [4:0] tens_swallow_counter;
  logic [15:0] swal_cnt;
  logic [1:0] sel;
  logic err;
  wire is_two = (cfg.mode == DMD_TWO);
  wire is_four = (cfg.mode == DMD_FOUR);
  wire is_three = (cfg.mode == DMD_THREE);
  wire [4:0] units_set = cfg.swal_val[`DMD_UNITS_SHIFT +: 5];
  wire [4:0] tens_set = cfg.swal_val[`DMD_TENS_SHIFT +: 5];
  // terminal state: last prescaler output of the cycle
  wire main_term = (main_cnt <= 16'h0001);
  wire units_nz = (units_swallow_counter != 5'h00);
  wire tens_nz = (tens_swallow_counter != 5'h00);
  // series mode: tens counter runs only once units has run out
  wire tens_run = is_three ? !units_nz : 1'b1;
  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) // RULE1
  begin
    if (!aresetn || main_term) // RULE3 RULE14
    begin
      main_cnt <= aresetn ? cfg.main_val : `DMD_MAIN_RST;
      swal_cnt <= aresetn ? cfg.swal_val : `DMD_SWAL_RST;
      units_swallow_counter <= aresetn ? units_set : 5'h00;
      tens_swallow_counter <= aresetn ? tens_set : 5'h00;
      cycle_end <= aresetn;
    end
    else
    begin
      main_cnt <= main_cnt - 16'h0001;
      cycle_end <= 1'b0;
      if (swal_cnt != 16'h0000)
        swal_cnt <= swal_cnt - 16'h0001;
      if (units_nz)
        units_swallow_counter <= units_swallow_counter - 5'h01; // RULE10
      if (tens_nz && tens_run)
        tens_swallow_counter <= tens_swallow_counter - 5'h01; // RULE9 RULE12
    end
  end
  // ---------------------------------------------------------------
  // modulus select, registered so it settles within one period
  // ---------------------------------------------------------------
  wire [1:0] next_sel = main_term ? {1'b0, 1'b0} :
                        is_two ? {1'b0, swal_cnt != 16'h0000} : // RULE2 RULE4
                        {tens_nz && tens_run, units_nz}; // RULE8
  wire next_err = is_two ? (cfg.main_val <= cfg.swal_val) :
                  is_four ? (units_set > `DMD_UNITS_MAX_PAR || tens_set > `DMD_TENS_MAX
                             || cfg.main_val < `DMD_MAIN_MIN_PAR) : // RULE11
                  is_three ? (units_set < `DMD_UNITS_MIN_SER || units_set > `DMD_UNITS_MAX_SER
                              || tens_set > `DMD_TENS_MAX
                              || cfg.main_val < `DMD_MAIN_MIN_SER) :
                  1'b1;
  always_ff @(posedge aclk) // RULE13
  begin
    if (!aresetn)
      sel <= 2'b00;
    else
      sel <= main_term ? {1'b0, 1'b0} : next_sel;
    if (!aresetn)
      err <= 1'b0;
    else
      err <= next_err; // RULE5
  end
  assign modulus_sel = sel;
  assign cfg.main_cnt = main_cnt;
  assign cfg.swal_cnt = swal_cnt;
  assign cfg.mod_sel = sel[0];
  assign cfg.cfg_err = err;
endmodule

// >>> rtl/dmd_top.sv
// dual modulus divider control: axi4-lite slave and counter core
//
// Behaviour
// RULE1: prescaler output clocks both counters together
// RULE2: larger modulus while swallow nonzero, then base
// RULE3: main terminal state reloads both counters
// RULE4: ratio equals main times P plus swallow times Q
// RULE5: software keeps main above swallow
// RULE6: swallow range spans at least ten values
// RULE7: swallow gives lowest digit, main the rest
// RULE8: four-modulus: two swallow counters in parallel
// RULE9: tens counter adds ten, set zero to nine
// RULE10: units counter adds one, set zero to nine
// RULE11: main at least larger swallow, minimum ten
// RULE12: three-modulus: series counters, units ten-nineteen, main twenty
// RULE13: select settles within one prescaler period
// RULE14: reload and pulse end of cycle to comparator
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "dmd_params.svh"
module dmd_top
(
  input wire logic aclk, // prescaler output clock, 100 MHz nominal
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [1:0] modulus_sel, // prescaler modulus select
  output logic cycle_end // end of division cycle pulse
);
  import dmd_pkg::*;
  dmd_cfg_if cfg ();
  logic [15:0] main_val;
  logic [15:0] swal_val;
  logic [1:0] mode;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] sticky;
  // ---------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held || aw_take;
  wire w_have = w_held || w_take;
  wire do_write = aw_have && w_have;
  wire [11:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_main = (wr_addr == `DMD_REG_MAIN);
  wire wr_swal = (wr_addr == `DMD_REG_SWAL);
  wire wr_mode = (wr_addr == `DMD_REG_MODE);
  wire wr_stat = (wr_addr == `DMD_REG_STAT);
  wire wr_hit = wr_main || wr_swal || wr_mode || wr_stat;
  wire [15:0] wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [15:0] wlow = wr_data[15:0];
  // error sticky: set wins over write-one-to-clear
  wire [15:0] next_sticky = (sticky & ~((do_write && wr_stat) ? (wlow & wmask) : 16'h0000))
                            | {15'h0000, cfg.cfg_err};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DMD_RESP_OKAY;
      main_val <= `DMD_MAIN_RST;
      swal_val <= `DMD_SWAL_RST;
      mode <= DMD_TWO;
      sticky <= 16'h0000;
    end
    else
    begin
      sticky <= next_sticky;
      if (aw_take)
        aw_addr <= s_axi_awaddr;
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held <= aw_have && !do_write;
      w_held <= w_have && !do_write;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `DMD_RESP_OKAY : `DMD_RESP_SLVERR;
        if (wr_main)
          main_val <= (main_val & ~wmask) | (wlow & wmask); // RULE7
        if (wr_swal)
          swal_val <= (swal_val & ~wmask) | (wlow & wmask); // RULE6
        if (wr_mode && wr_strb[0])
          mode <= wr_data[1:0];
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_main = (s_axi_araddr == `DMD_REG_MAIN);
  wire rd_swal = (s_axi_araddr == `DMD_REG_SWAL);
  wire rd_mode = (s_axi_araddr == `DMD_REG_MODE);
  wire rd_stat = (s_axi_araddr == `DMD_REG_STAT);
  wire rd_hit = rd_main || rd_swal || rd_mode || rd_stat;
  wire [31:0] stat_word = {cfg.swal_cnt[7:0], cfg.main_cnt[7:0], 13'h0000,
                           cfg.cfg_err, cfg.mod_sel, sticky[0]};
  wire [31:0] rd_word = rd_main ? {16'h0000, main_val} :
                        rd_swal ? {16'h0000, swal_val} :
                        rd_mode ? {30'h00000000, mode} :
                        rd_stat ? stat_word : 32'h00000000;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DMD_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `DMD_RESP_OKAY : `DMD_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // ---------------------------------------------------------------
  // counter core
  // ---------------------------------------------------------------
  assign cfg.main_val = main_val;
  assign cfg.swal_val = swal_val;
  assign cfg.mode = mode;
  dmd_counters u_counters
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg),
    .modulus_sel(modulus_sel),
    .cycle_end(cycle_end)
  );
endmodule

// >>> tb/dmd_top_assertions.sv
// port-level checks for the divider control top
`timescale 1ns/10ps
module dmd_top_assertions
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [1:0] modulus_sel, // modulus select
  input wire logic cycle_end // cycle pulse
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_cycle_spacing: assert property (cycle_end |=> !cycle_end [*2])
    else $error("cycle pulses too close");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !cycle_end && modulus_sel == 2'h0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset edge");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
endmodule
bind dmd_top dmd_top_assertions i_dmd_top_assertions (.*);

// >>> tb/dmd_prescaler_model.sv
// prescaler model: counts modulus steps in each division cycle
`timescale 1ns/10ps
module dmd_prescaler_model
(
  input wire logic aclk, // prescaler output clock
  input wire logic aresetn, // reset, active low
  input wire logic [1:0] modulus_sel, // modulus select from block
  input wire logic cycle_end, // end of division cycle
  output logic rep_v, // report strobe
  output logic [7:0] rep_len, // output periods in last cycle
  output logic [7:0] rep_c0, // periods with unit step added
  output logic [7:0] rep_c1 // periods with tens step added
);
  logic [7:0] len, c0, c1;
  // select seen at each edge sets the modulus of the next period
  always_ff @(posedge aclk)
  begin
    rep_v <= aresetn && cycle_end;
    if (!aresetn || cycle_end)
    begin
      rep_len <= len + 8'h01;
      rep_c0 <= c0 + {7'h00, modulus_sel[0]};
      rep_c1 <= c1 + {7'h00, modulus_sel[1]};
      len <= 8'h00;
      c0 <= 8'h00;
      c1 <= 8'h00;
    end
    else
    begin
      len <= len + 8'h01;
      c0 <= c0 + {7'h00, modulus_sel[0]};
      c1 <= c1 + {7'h00, modulus_sel[1]};
    end
  end
endmodule

// >>> tb/dmd_top_test.sv
// self-checking bench for the divider control block
`timescale 1ns/10ps
`include "dmd_params.svh"
module dmd_top_test;
  import dmd_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, cycle_end, rep_v;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, x;
  logic [1:0] bresp, rresp, modulus_sel;
  logic [7:0] rep_len, rep_c0, rep_c1;
  logic [33:0] rq[$], mq[$], e, m;
  logic [23:0] cq[$], c;
  int miscompares, samples_checked, u, t, n, i;
  dmd_top i_dmd_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .modulus_sel(modulus_sel), .cycle_end(cycle_end));
  dmd_prescaler_model i_dmd_prescaler_model (.aclk(aclk), .aresetn(aresetn),
    .modulus_sel(modulus_sel), .cycle_end(cycle_end), .rep_v(rep_v),
    .rep_len(rep_len), .rep_c0(rep_c0), .rep_c1(rep_c1));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task give_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cmp(input logic [33:0] g, input logic [33:0] ex, input logic [33:0] mk);
    samples_checked++;
    if (((g ^ ex) & mk) !== 34'h0)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, g, ex);
    end
  endtask
  // bus tasks start just after a rising edge; ready is raised once valid shows
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, 32'h0});
    mq.push_back(34'h300000000);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= bvalid && !bready;
    end while (!(bvalid && bready));
  endtask
  task rd(input logic [11:0] a, input logic [33:0] ex, input logic [33:0] mk);
    rq.push_back(ex);
    mq.push_back(mk);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      rready <= rvalid && !rready;
    end while (!(rvalid && rready));
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
    if ((bvalid && bready) || (rvalid && rready))
    begin
      e = rq.pop_front();
      m = mq.pop_front();
      cmp((bvalid && bready) ? {bresp, 32'h0} : {rresp, rdata}, e, m);
    end
  always @(negedge aclk)
    if (rep_v === 1'b1 && cq.size() > 0)
    begin
      c = cq.pop_front();
      cmp({10'h0, rep_len, rep_c0, rep_c1}, {10'h0, c}, 34'hFFFFFF);
    end
  initial
  begin
    #300000;
    miscompares++;
    give_verdict;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 56'h0;
    x = 32'd50;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`DMD_REG_MAIN, {2'h0, 32'h0000000A}, 34'h3FFFFFFFF);
    rd(`DMD_REG_SWAL, 34'h0, 34'h3FFFFFFFF);
    rd(12'h010, {`DMD_RESP_SLVERR, 32'h0}, 34'h3FFFFFFFF);
    wr(12'h010, 32'h0, `DMD_RESP_SLVERR);
    wr(`DMD_REG_MODE, {30'h0, DMD_TWO}, `DMD_RESP_OKAY);
    wr(`DMD_REG_MAIN, 32'h3, `DMD_RESP_OKAY);
    wr(`DMD_REG_SWAL, 32'h5, `DMD_RESP_OKAY);
    repeat (4) @(posedge aclk);
    rd(`DMD_REG_STAT, 34'h5, 34'h5);
    wr(`DMD_REG_SWAL, 32'h1, `DMD_RESP_OKAY);
    wr(`DMD_REG_STAT, 32'h1, `DMD_RESP_OKAY);
    rd(`DMD_REG_STAT, 34'h0, 34'h5);
    for (i = 0; i < 6; i++)
    begin
      x = xs(x);
      u = x % 10;
      t = (x >> 8) % 10;
      n = (i % 3 == 0) ? 11 + (x >> 16) % 20 : (i % 3 == 1) ? 10 + (x >> 16) % 10 : 30;
      if (i % 3 == 2) u = u + 10;
      wr(`DMD_REG_MODE, i % 3, `DMD_RESP_OKAY);
      wr(`DMD_REG_MAIN, n, `DMD_RESP_OKAY);
      wr(`DMD_REG_SWAL, (i % 3 == 0) ? u : (t << 8) | u, `DMD_RESP_OKAY);
      repeat (3)
      begin
        @(posedge aclk);
        while (cycle_end !== 1'b1) @(posedge aclk);
      end
      cq.push_back({n[7:0], u[7:0], (i % 3 == 0) ? 8'h00 : t[7:0]});
      while (cq.size() > 0) @(posedge aclk);
    end
    give_verdict;
  end
endmodule
